// *** rtl/pid_pkg.sv ***
// Behaviour
// R1: the proportional term is refreshed every 128 clocks as error times the unsigned gain over 256, clipped to 32-bit range, and a zero gain gives zero.
// R2: the integral term is the accumulator over 256 times the unsigned gain over 256, clipped to 32-bit range, and a zero gain gives zero.
// R3: the error is sampled at the derivative rate and the term is last minus current sample, clipped to +/-127, times the unsigned gain.
// R4: the derivative rate is the clock over 128 times the 8-bit divider, with a divider of zero acting as 256.
// R5: the signed 32-bit accumulator is updated every 128 clocks, limited to 2^16 times its limit setting, and any write to it clears it.
// R6: velocity is the result clipped to the correction limit (low 8 bits zero), plus ramp velocity with base select 1; a zero limit disables correction.
// R7: the position error is encoder minus ramp position clipped to +/-2^23 and is readable.
// R8: with base select 0 the report is the clipped result alone, with 1 it is result plus ramp velocity clipped to 32-bit range.
// R9: after an exact hit and while the absolute error is below the 20-bit deadband, the error input is zero and the accumulator is held at zero.
// R10: the result is the sum of the proportional, integral and derivative terms before the limit.
package pid_pkg;
   localparam int ADDR_W = 7;
   localparam logic [6:0] ADDR_P_GAIN = 7'h20;
   localparam logic [6:0] ADDR_I_GAIN = 7'h21;
   localparam logic [6:0] ADDR_D_GAIN = 7'h22;
   localparam logic [6:0] ADDR_I_LIMIT = 7'h23;
   localparam logic [6:0] ADDR_I_ACC = 7'h24;
   localparam logic [6:0] ADDR_D_DIV = 7'h25;
   localparam logic [6:0] ADDR_CORR_LIMIT = 7'h27;
   localparam logic [6:0] ADDR_POS_ERR = 7'h28;
   localparam logic [6:0] ADDR_REG_VEL = 7'h29;
   localparam logic [6:0] ADDR_DEADBAND = 7'h2a;
   localparam int PRESCALE = 128;
   localparam int GAIN_SHIFT = 8;
   localparam int ILIM_SHIFT = 16;
   localparam int LIMIT_LOW_BITS = 8;
   localparam logic [8:0] DIV_ZERO_VALUE = 9'h100;
   localparam logic signed [63:0] DELTA_LIM = 64'sh7f;
   localparam logic signed [63:0] ERR_LIM = 64'sh80_0000;
   localparam logic signed [63:0] V_MAX = 64'sh7fff_ffff;
   localparam logic signed [63:0] V_MIN = -64'sh8000_0000;
   localparam logic [31:0] RESET_VALUE = 32'h0;
endpackage : pid_pkg

// *** rtl/pid_position_regulator.sv ***
`timescale 1ns/10ps
module pid_position_regulator
   import pid_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [6:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   output logic [31:0] reg_rdata,
   input wire logic [31:0] enc_pos,
   input wire logic [31:0] ramp_pos,
   input wire logic [31:0] ramp_vel,
   input wire logic exact_hit,
   input wire logic base_select,
   output logic [31:0] regulated_velocity
);
   logic [23:0] p_gain_reg;
   logic [23:0] i_gain_reg;
   logic [23:0] d_gain_reg;
   logic [14:0] i_limit_reg;
   logic [7:0] d_div_reg;
   logic [30:0] corr_limit_reg;
   logic [19:0] deadband_reg;
   logic signed [31:0] isum_reg;
   logic signed [31:0] err_reg;
   logic signed [31:0] err_last_reg;
   logic signed [31:0] p_term_reg;
   logic signed [31:0] i_term_reg;
   logic signed [31:0] d_term_reg;
   logic signed [31:0] corr_reg;
   logic zone_reg;
   logic base_tick;
   logic d_tick;

   function automatic logic signed [63:0] clip(input logic signed [63:0] v,
         input logic signed [63:0] lo, input logic signed [63:0] hi);
      clip = (v > hi) ? hi : ((v < lo) ? lo : v);
   endfunction : clip

   function automatic logic signed [63:0] sx32(input logic [31:0] v);
      sx32 = {{32{v[31]}}, v};
   endfunction : sx32

   pid_tick_gen u_ticks (
      .core_clk(core_clk),
      .srst(srst),
      .d_div(d_div_reg),
      .base_tick(base_tick),
      .d_tick(d_tick)
   );

   wire logic wr_hit_acc = reg_wr && (reg_addr == ADDR_I_ACC);
   // error path
   wire logic signed [63:0] err_sat = clip(sx32(enc_pos) - sx32(ramp_pos), -ERR_LIM, ERR_LIM); // R7
   wire logic signed [63:0] err_abs = (err_sat < 0) ? -err_sat : err_sat;
   wire logic in_band = err_abs < $signed({44'h0, deadband_reg});
   wire logic zone_next = in_band && (zone_reg || exact_hit); // R9
   wire logic signed [63:0] err_in = zone_next ? 64'sh0 : err_sat; // R9
   // proportional
   wire logic signed [63:0] p_full = (err_in * $signed({40'h0, p_gain_reg})) >>> GAIN_SHIFT;
   wire logic signed [63:0] p_next = clip(p_full, V_MIN, V_MAX); // R1
   // integral
   wire logic signed [63:0] i_lim = $signed({33'h0, i_limit_reg, 16'h0});
   wire logic signed [63:0] isum_next = clip(sx32(isum_reg) + err_in, -i_lim, i_lim); // R5
   wire logic signed [63:0] i_full =
      ((sx32(isum_reg) >>> GAIN_SHIFT) * $signed({40'h0, i_gain_reg})) >>> GAIN_SHIFT;
   wire logic signed [63:0] i_next = clip(i_full, V_MIN, V_MAX); // R2
   // derivative
   wire logic signed [63:0] delta = clip(sx32(err_last_reg) - err_in, -DELTA_LIM, DELTA_LIM); // R3
   wire logic signed [63:0] d_next = delta * $signed({40'h0, d_gain_reg}); // R3
   // combine and limit
   wire logic signed [63:0] pid_sum = sx32(p_term_reg) + sx32(i_term_reg) + sx32(d_term_reg); // R10
   wire logic signed [63:0] corr_lim =
      $signed({33'h0, corr_limit_reg[30:LIMIT_LOW_BITS], 8'h00}); // R6
   wire logic signed [63:0] corr_next = clip(pid_sum, -corr_lim, corr_lim); // R6
   wire logic signed [63:0] vel_sum = clip(sx32(ramp_vel) + sx32(corr_reg), V_MIN, V_MAX); // R8
   wire logic [31:0] vel_next = base_select ? vel_sum[31:0] : corr_reg; // R8
   wire logic [31:0] rd_next =
      (reg_addr == ADDR_I_ACC) ? isum_reg :
      (reg_addr == ADDR_POS_ERR) ? err_reg :
      (reg_addr == ADDR_REG_VEL) ? regulated_velocity : RESET_VALUE;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         p_gain_reg <= 24'h0;
         i_gain_reg <= 24'h0;
         d_gain_reg <= 24'h0;
         i_limit_reg <= 15'h0;
         d_div_reg <= 8'h0;
         corr_limit_reg <= 31'h0;
         deadband_reg <= 20'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_P_GAIN: p_gain_reg <= reg_wdata[23:0];
            ADDR_I_GAIN: i_gain_reg <= reg_wdata[23:0];
            ADDR_D_GAIN: d_gain_reg <= reg_wdata[23:0];
            ADDR_I_LIMIT: i_limit_reg <= reg_wdata[14:0];
            ADDR_D_DIV: d_div_reg <= reg_wdata[7:0];
            ADDR_CORR_LIMIT: corr_limit_reg <= {reg_wdata[30:8], 8'h00}; // R6
            ADDR_DEADBAND: deadband_reg <= reg_wdata[19:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         isum_reg <= 32'sh0;
         zone_reg <= 1'b0;
      end else begin
         zone_reg <= zone_next;
         if (wr_hit_acc || zone_next) begin
            isum_reg <= 32'sh0; // R5 R9
         end else if (base_tick) begin
            isum_reg <= isum_next[31:0]; // R5
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         err_reg <= 32'sh0;
         p_term_reg <= 32'sh0;
         i_term_reg <= 32'sh0;
      end else if (base_tick) begin
         err_reg <= err_sat[31:0]; // R7
         p_term_reg <= p_next[31:0]; // R1
         i_term_reg <= i_next[31:0]; // R2
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         err_last_reg <= 32'sh0;
         d_term_reg <= 32'sh0;
      end else if (d_tick) begin
         err_last_reg <= err_in[31:0]; // R3
         d_term_reg <= d_next[31:0]; // R3
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         corr_reg <= 32'sh0;
         regulated_velocity <= RESET_VALUE;
         reg_rdata <= RESET_VALUE;
      end else begin
         corr_reg <= corr_next[31:0]; // R6
         regulated_velocity <= vel_next; // R8
         reg_rdata <= rd_next;
      end
   end

   // cycles since the last derivative sample, for the rate check
   logic [15:0] d_gap_reg;
   wire logic [8:0] d_div_eff = (d_div_reg == 8'h00) ? DIV_ZERO_VALUE : {1'b0, d_div_reg};
   wire logic [15:0] d_period = 16'(PRESCALE) * {7'h00, d_div_eff};
   wire logic wr_hit_div = reg_wr && (reg_addr == ADDR_D_DIV);

   always_ff @(posedge core_clk) begin
      if (srst || d_tick || wr_hit_div) begin
         d_gap_reg <= 16'h0000;
      end else if (d_gap_reg != 16'hffff) begin
         d_gap_reg <= d_gap_reg + 16'h0001;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   p_zero_gain_a: assert property (base_tick && p_gain_reg == 24'h0 |=> p_term_reg == 0) // R1
      else $error("proportional term not zero with zero gain");
   i_zero_gain_a: assert property (base_tick && i_gain_reg == 24'h0 |=> i_term_reg == 0) // R2
      else $error("integral term not zero with zero gain");
   d_range_a: assert property (d_tick |=> (d_term_reg <= 127 * $signed({8'h0, d_gain_reg})) && // R3
      (d_term_reg >= -127 * $signed({8'h0, d_gain_reg}))) else $error("derivative out of range");
   acc_clear_a: assert property (wr_hit_acc |=> isum_reg == 0) // R5
      else $error("accumulator not cleared by write");
   acc_limit_a: assert property (sx32(isum_reg) <= i_lim && sx32(isum_reg) >= -i_lim) // R5
      else $error("accumulator beyond limit");
   corr_off_a: assert property (corr_limit_reg == 31'h0 |=> corr_reg == 0) // R6
      else $error("correction not disabled by zero limit");
   err_clip_a: assert property (sx32(err_reg) <= ERR_LIM && sx32(err_reg) >= -ERR_LIM) // R7
      else $error("position error beyond clip");
   base_zero_a: assert property (!base_select |=> regulated_velocity == $past(corr_reg)) // R8
      else $error("report not result alone");
   zone_hold_a: assert property (zone_reg && $past(zone_reg) |-> isum_reg == 0) // R9
      else $error("accumulator not held in deadband");
   sum_terms_a: assert property (corr_limit_reg == 31'h7fff_ff00 && $stable(corr_limit_reg) // R10
      |=> corr_reg == clip($past(pid_sum), -$past(corr_lim), $past(corr_lim)))
      else $error("result not sum of terms");

   // sampling, holding and bounds
   err_sample_a: assert property (base_tick |=> err_reg == $past(err_sat[31:0])) // R7
      else $error("position error not sampled on tick");
   err_read_a: assert property (reg_addr == ADDR_POS_ERR |=> reg_rdata == $past(err_reg)) // R7
      else $error("position error read wrong");
   vel_base_one_a: assert property (base_select |=> regulated_velocity == $past(vel_sum[31:0])) // R8
      else $error("report not result plus ramp velocity");
   rd_vel_a: assert property (reg_addr == ADDR_REG_VEL |=> reg_rdata == $past(regulated_velocity)) // R8
      else $error("regulated velocity read wrong");
   d_zero_gain_a: assert property (d_tick && d_gain_reg == 24'h0 |=> d_term_reg == 0) // R3
      else $error("derivative term not zero with zero gain");
   err_last_a: assert property (d_tick |=> err_last_reg == $past(err_in[31:0])) // R3
      else $error("derivative sample not taken");
   d_hold_a: assert property (!d_tick |=> $stable(d_term_reg)) // R4
      else $error("derivative term changed off its tick");
   d_gap_a: assert property (d_tick |-> d_gap_reg <= d_period) // R4
      else $error("derivative rate too slow");
   term_hold_a: assert property (!base_tick |=> $stable(p_term_reg) && $stable(i_term_reg)) // R1
      else $error("terms changed off base tick");
   p_sign_a: assert property (base_tick && p_gain_reg != 24'h0 && err_in > 0 |=> p_term_reg >= 0) // R1
      else $error("proportional term of wrong sign");
   p_input_zero_a: assert property (base_tick && err_in == 0 |=> p_term_reg == 0) // R1
      else $error("proportional term not zero with zero error");
   i_sign_a: assert property (base_tick && i_gain_reg != 24'h0 && isum_reg >= 0 |=> i_term_reg >= 0) // R2
      else $error("integral term of wrong sign");
   acc_hold_a: assert property (!base_tick && !wr_hit_acc && !zone_next |=> $stable(isum_reg)) // R5
      else $error("accumulator changed off base tick");
   corr_bound_a: assert property (1'b1 |=> sx32(corr_reg) <= $past(corr_lim) && // R6
      sx32(corr_reg) >= -$past(corr_lim)) else $error("correction beyond limit");
   zone_entry_a: assert property (exact_hit && in_band |=> isum_reg == 0) // R9
      else $error("accumulator not cleared on zone entry");
   zone_leave_a: assert property (!in_band |=> !zone_reg) // R9
      else $error("deadband zone not left");
endmodule : pid_position_regulator

// *** rtl/pid_tick_gen.sv ***
`timescale 1ns/10ps
module pid_tick_gen
   import pid_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] d_div,
   output logic base_tick,
   output logic d_tick
);
   logic [6:0] pre_reg;
   logic [8:0] dcnt_reg;
   wire logic [8:0] div_eff = (d_div == 8'h00) ? DIV_ZERO_VALUE : {1'b0, d_div}; // R4
   wire logic pre_wrap = (pre_reg == 7'(PRESCALE - 1));
   wire logic d_wrap = (dcnt_reg >= div_eff - 9'h001);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pre_reg <= 7'h00;
         dcnt_reg <= 9'h000;
         base_tick <= 1'b0;
         d_tick <= 1'b0;
      end else begin
         pre_reg <= pre_reg + 7'h01;
         base_tick <= pre_wrap; // R1
         d_tick <= pre_wrap && d_wrap; // R4
         if (pre_wrap) begin
            dcnt_reg <= d_wrap ? 9'h000 : dcnt_reg + 9'h001;
         end
      end
   end

   gap_a: assert property (@(posedge core_clk) disable iff (srst)
      base_tick |=> !base_tick [*8]) else $error("base tick too frequent"); // R1
   dtick_a: assert property (@(posedge core_clk) disable iff (srst)
      d_tick |-> base_tick) else $error("derivative tick off base tick"); // R4
endmodule : pid_tick_gen

// *** verif/ramp_encoder_model.sv ***
`timescale 1ns/10ps
module ramp_encoder_model (
   input wire logic core_clk,
   input wire logic [31:0] enc_set,
   input wire logic [31:0] ramp_set,
   input wire logic [31:0] vel_set,
   input wire logic hit_set,
   output logic [31:0] enc_pos,
   output logic [31:0] ramp_pos,
   output logic [31:0] ramp_vel,
   output logic exact_hit
);
   // counters present registered values, one clock behind the request
   initial begin
      enc_pos = 32'h0;
      ramp_pos = 32'h0;
      ramp_vel = 32'h0;
      exact_hit = 1'b0;
   end
   always @(posedge core_clk) begin
      enc_pos <= enc_set;
      ramp_pos <= ramp_set;
      ramp_vel <= vel_set;
      exact_hit <= hit_set;
   end
endmodule : ramp_encoder_model

// *** verif/tb_pid_position_regulator.sv ***
`timescale 1ns/10ps
module tb_pid_position_regulator;
   import pid_pkg::*;
   logic core_clk, srst, reg_wr, base_select, hit_set;
   logic [6:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, regulated_velocity, enc_pos, ramp_pos, ramp_vel;
   logic [31:0] enc_set, ramp_set, vel_set;
   logic exact_hit;
   int errors, check_count;
   pid_position_regulator dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .enc_pos(enc_pos),
      .ramp_pos(ramp_pos), .ramp_vel(ramp_vel), .exact_hit(exact_hit),
      .base_select(base_select), .regulated_velocity(regulated_velocity));
   ramp_encoder_model far_side (.core_clk(core_clk), .enc_set(enc_set), .ramp_set(ramp_set),
      .vel_set(vel_set), .hit_set(hit_set), .enc_pos(enc_pos), .ramp_pos(ramp_pos),
      .ramp_vel(ramp_vel), .exact_hit(exact_hit));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic report_and_stop;
      $display("errors %0d, checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic chk_rd(input logic [6:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      @(posedge core_clk);
      #1 cmp(reg_rdata, exp);
   endtask : chk_rd
   task automatic pos(input logic [31:0] e, r, v, input logic b, h);
      @(posedge core_clk);
      enc_set <= e;
      ramp_set <= r;
      vel_set <= v;
      base_select <= b;
      hit_set <= h;
   endtask : pos
   // three base ticks cover term, correction and output stages
   task automatic chk_vel(input logic [31:0] exp);
      repeat (3 * PRESCALE) @(posedge core_clk);
      #1 cmp(regulated_velocity, exp);
   endtask : chk_vel
   // waits for a value that stands only for one derivative period
   task automatic seek_vel(input logic [31:0] exp);
      for (int i = 0; i < 1000; i++) begin
         @(posedge core_clk);
         #1;
         if (regulated_velocity === exp) break;
      end
      cmp(regulated_velocity, exp);
   endtask : seek_vel
   initial begin
      #1000000;
      errors++;
      report_and_stop();
   end
   initial begin
      srst = 1'b1;
      {reg_wr, base_select, hit_set} = 3'h0;
      reg_addr = 7'h0;
      {reg_wdata, enc_set, ramp_set, vel_set} = 128'h0;
      errors = 0;
      check_count = 0;
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      chk_rd(ADDR_I_ACC, 32'h0);
      chk_vel(32'h0);
      wr(7'h26, 32'h1234_5678);
      chk_rd(7'h26, 32'h0);
      pos(32'h5, 32'h0, 32'h0, 1'b0, 1'b0);
      wr(ADDR_P_GAIN, 32'h100);
      wr(ADDR_CORR_LIMIT, 32'h7fff_ff00);
      chk_vel(32'h5);
      chk_rd(ADDR_POS_ERR, 32'h5);
      pos(32'h5, 32'h0, 32'h64, 1'b1, 1'b0);
      chk_vel(32'h69);
      pos(32'h5, 32'h0, 32'h7fff_ffff, 1'b1, 1'b0);
      chk_vel(32'h7fff_ffff);
      pos(32'h3e8, 32'h0, 32'h0, 1'b0, 1'b0);
      wr(ADDR_CORR_LIMIT, 32'h1ff);
      chk_vel(32'h100);
      pos(32'h0, 32'h3e8, 32'h0, 1'b0, 1'b0);
      chk_vel(32'hffff_ff00);
      wr(ADDR_CORR_LIMIT, 32'h0);
      chk_vel(32'h0);
      wr(ADDR_CORR_LIMIT, 32'h7fff_ff00);
      wr(ADDR_P_GAIN, 32'hff_ffff);
      pos(32'h4000_0000, 32'h0, 32'h0, 1'b0, 1'b0);
      chk_vel(32'h7fff_ff00);
      chk_rd(ADDR_POS_ERR, 32'h0080_0000);
      pos(32'h0, 32'h4000_0000, 32'h0, 1'b0, 1'b0);
      chk_vel(32'h8000_0100);
      chk_rd(ADDR_POS_ERR, 32'hff80_0000);
      wr(ADDR_P_GAIN, 32'h0);
      wr(ADDR_I_LIMIT, 32'h1);
      pos(32'h4000_0000, 32'h0, 32'h0, 1'b0, 1'b0);
      chk_vel(32'h0);
      chk_rd(ADDR_I_ACC, 32'h0001_0000);
      wr(ADDR_I_GAIN, 32'h3);
      chk_vel(32'h3);
      wr(ADDR_DEADBAND, 32'h100);
      pos(32'h5, 32'h0, 32'h0, 1'b0, 1'b1);
      chk_vel(32'h0);
      chk_rd(ADDR_I_ACC, 32'h0);
      chk_rd(ADDR_POS_ERR, 32'h5);
      chk_rd(ADDR_REG_VEL, 32'h0);
      wr(ADDR_I_GAIN, 32'h0);
      wr(ADDR_DEADBAND, 32'h0);
      wr(ADDR_D_DIV, 32'h3);
      pos(32'h0, 32'h0, 32'h0, 1'b0, 1'b0);
      chk_vel(32'h0);
      wr(ADDR_D_GAIN, 32'h2);
      pos(32'h3e8, 32'h0, 32'h0, 1'b0, 1'b0);
      seek_vel(32'hffff_ff02);
      seek_vel(32'h0);
      report_and_stop();
   end
endmodule : tb_pid_position_regulator
